// ===== hdl/rtc_hold_pkg.sv
// Shared constants and types for the calendar counter hold block
package rtc_hold_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SUB_W = 16;
    localparam logic [SUB_W-1:0] SUB_MAX = 16'hFFFF;

    // Register byte addresses, one word each
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SUB = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SEC = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_MIN = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_HOUR = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_DAY = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_WEEK = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_MONTH = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_YEAR = 8'h24;

    // Bit positions in control and status words
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int STAT_HOLD_BIT = 0;
    localparam int STAT_PEND_BIT = 1;

    // Counter limits
    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] WEEK_MAX = 3'h6;
    localparam logic [3:0] MONTH_MAX = 4'hC;
    localparam logic [6:0] YEAR_MAX = 7'h63;
    localparam logic [4:0] DAY_FIRST = 5'h01;
    localparam logic [3:0] MONTH_FIRST = 4'h1;
    localparam logic [3:0] MONTH_FEB = 4'h2;
    localparam logic [4:0] DAYS_31 = 5'h1F;
    localparam logic [4:0] DAYS_30 = 5'h1E;
    localparam logic [4:0] DAYS_29 = 5'h1D;
    localparam logic [4:0] DAYS_28 = 5'h1C;

    typedef enum logic [2:0] {
        FLD_SEC = 3'h0, FLD_MIN = 3'h1, FLD_HOUR = 3'h2, FLD_DAY = 3'h3,
        FLD_WEEK = 3'h4, FLD_MONTH = 3'h5, FLD_YEAR = 3'h6
    } field_type;

    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [2:0] week;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } cal_type;

    typedef struct packed {
        logic en;
        field_type field;
        logic [6:0] data;
    } cal_load_type;

    localparam cal_type CAL_RST = '{year: 7'h00, month: 4'h1, week: 3'h0, day: 5'h01,
                                    hour: 5'h00, min: 6'h00, sec: 6'h00};

    // Hold handshake states
    typedef enum logic [2:0] {
        HS_RUN = 3'h1,
        HS_WAIT = 3'h2,
        HS_HELD = 3'h4
    } hold_state_type;
endpackage

// ===== hdl/rtc_calendar.sv
// Seconds-through-years calendar counter chain with software load
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire rtc_hold_pkg::cal_load_type ld,
    output rtc_hold_pkg::cal_type q
);
    logic [4:0] month_len;

    // Month length; every fourth year is a leap year within the 0..99 range
    always_comb begin
        case (q.month)
            4'h4, 4'h6, 4'h9, 4'hB: month_len = rtc_hold_pkg::DAYS_30;
            rtc_hold_pkg::MONTH_FEB: month_len = (q.year[1:0] == 2'h0) ?
                rtc_hold_pkg::DAYS_29 : rtc_hold_pkg::DAYS_28;
            default: month_len = rtc_hold_pkg::DAYS_31;
        endcase
    end

    // Load beats tick, so a written value is never bumped in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= rtc_hold_pkg::CAL_RST;
        end else if (ld.en) begin
            case (ld.field)
                rtc_hold_pkg::FLD_SEC: q.sec <= ld.data[5:0];
                rtc_hold_pkg::FLD_MIN: q.min <= ld.data[5:0];
                rtc_hold_pkg::FLD_HOUR: q.hour <= ld.data[4:0];
                rtc_hold_pkg::FLD_DAY: q.day <= ld.data[4:0];
                rtc_hold_pkg::FLD_WEEK: q.week <= ld.data[2:0];
                rtc_hold_pkg::FLD_MONTH: q.month <= ld.data[3:0];
                rtc_hold_pkg::FLD_YEAR: q.year <= ld.data[6:0];
                default: ;
            endcase
        end else if (tick) begin
            if (q.sec != rtc_hold_pkg::SEC_MAX) begin
                q.sec <= q.sec + 6'h01;
            end else begin
                q.sec <= 6'h00;
                if (q.min != rtc_hold_pkg::MIN_MAX) begin
                    q.min <= q.min + 6'h01;
                end else begin
                    q.min <= 6'h00;
                    if (q.hour != rtc_hold_pkg::HOUR_MAX) begin
                        q.hour <= q.hour + 5'h01;
                    end else begin
                        q.hour <= 5'h00;
                        q.week <= (q.week == rtc_hold_pkg::WEEK_MAX) ? 3'h0 : q.week + 3'h1;
                        if (q.day < month_len) begin
                            q.day <= q.day + 5'h01;
                        end else begin
                            q.day <= rtc_hold_pkg::DAY_FIRST;
                            if (q.month != rtc_hold_pkg::MONTH_MAX) begin
                                q.month <= q.month + 4'h1;
                            end else begin
                                q.month <= rtc_hold_pkg::MONTH_FIRST;
                                q.year <= (q.year == rtc_hold_pkg::YEAR_MAX) ?
                                    7'h00 : q.year + 7'h01;
                            end
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== hdl/rtc_counter_access_hold.sv
// Real-time clock with a counter hold for safe software access
// Contract
// RULE_01: Hold request one freezes calendar counters.
// RULE_02: Software sets hold before counter access.
// RULE_03: Software releases hold within one second.
// RULE_04: Hold status rises one cycle after request.
// RULE_05: Overflow during hold applied at release.
// RULE_06: Seconds write during hold drops overflow.
// RULE_07: Hold right after run enable: two cycles.
// RULE_08: Hold right after standby exit: two cycles.
// RULE_09: Clearing hold drops status, counting resumes.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rtc_counter_access_hold (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [rtc_hold_pkg::ADDR_W-1:0] ADDR,
    input wire logic [rtc_hold_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic STANDBY_EXIT,
    output logic [rtc_hold_pkg::DATA_W-1:0] RDATA,
    output logic HOLD_STATUS
);
    logic rtc_run_enable_r;
    logic counter_hold_request_r;
    logic slow_r;
    logic evt_r;
    logic ovf_pend_r;
    logic [rtc_hold_pkg::SUB_W-1:0] sub_r;
    rtc_hold_pkg::hold_state_type state_r;
    rtc_hold_pkg::hold_state_type state_nxt;
    rtc_hold_pkg::cal_type cal_q;
    rtc_hold_pkg::cal_load_type ld;
    logic [rtc_hold_pkg::DATA_W-1:0] rd_mux;
    logic wr_ctrl;
    logic run_rise_now;
    logic hold_rise_now;
    logic sub_ovf;
    logic sec_wr;
    logic cal_tick;

    // Bus decode and event terms
    assign wr_ctrl = WR && (ADDR == rtc_hold_pkg::ADDR_CTRL);
    assign run_rise_now = wr_ctrl && WDATA[rtc_hold_pkg::CTRL_RUN_BIT] && !rtc_run_enable_r;
    assign hold_rise_now = wr_ctrl && WDATA[rtc_hold_pkg::CTRL_HOLD_BIT]
                           && !counter_hold_request_r;
    assign sub_ovf = rtc_run_enable_r && (sub_r == rtc_hold_pkg::SUB_MAX);
    assign sec_wr = WR && (ADDR == rtc_hold_pkg::ADDR_SEC);
    // Calendar advances only outside a hold, from live or stored overflow
    assign cal_tick = !counter_hold_request_r && (sub_ovf || ovf_pend_r); // [RULE_01] [RULE_05]

    // Control register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rtc_run_enable_r <= 1'b0;
            counter_hold_request_r <= 1'b0;
        end else if (wr_ctrl) begin
            rtc_run_enable_r <= WDATA[rtc_hold_pkg::CTRL_RUN_BIT];
            counter_hold_request_r <= WDATA[rtc_hold_pkg::CTRL_HOLD_BIT];
        end
    end

    // Sub-second counter keeps running during a hold; software must be quick
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sub_r <= '0;
        end else if (rtc_run_enable_r) begin
            sub_r <= sub_r + 16'h0001; // [RULE_03]
        end
    end

    // Run enable or standby exit in this or the last cycle marks a late hold
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            evt_r <= 1'b0;
        end else begin
            evt_r <= run_rise_now || STANDBY_EXIT;
        end
    end

    // Late hold request needs one extra synchronising cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            slow_r <= 1'b0;
        end else if (hold_rise_now) begin
            slow_r <= run_rise_now || STANDBY_EXIT || evt_r; // [RULE_07] [RULE_08]
        end else if (!counter_hold_request_r) begin
            slow_r <= 1'b0;
        end
    end

    // Hold handshake next state
    always_comb begin
        case (state_r)
            rtc_hold_pkg::HS_RUN: begin
                if (!counter_hold_request_r) begin
                    state_nxt = rtc_hold_pkg::HS_RUN;
                end else if (slow_r) begin
                    state_nxt = rtc_hold_pkg::HS_WAIT; // [RULE_07] [RULE_08]
                end else begin
                    state_nxt = rtc_hold_pkg::HS_HELD; // [RULE_04]
                end
            end
            rtc_hold_pkg::HS_WAIT: begin
                state_nxt = counter_hold_request_r ? rtc_hold_pkg::HS_HELD
                                                   : rtc_hold_pkg::HS_RUN;
            end
            rtc_hold_pkg::HS_HELD: begin
                state_nxt = counter_hold_request_r ? rtc_hold_pkg::HS_HELD
                                                   : rtc_hold_pkg::HS_RUN; // [RULE_09]
            end
            default: state_nxt = rtc_hold_pkg::HS_RUN;
        endcase
    end

    // Status flag is registered alongside the state so it reaches the pin glitch free
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= rtc_hold_pkg::HS_RUN;
            HOLD_STATUS <= 1'b0;
        end else begin
            state_r <= state_nxt;
            HOLD_STATUS <= (state_nxt == rtc_hold_pkg::HS_HELD); // [RULE_04] [RULE_09]
        end
    end

    // Stored overflow; a new overflow wins over any clear in the same cycle while a hold is requested or an overflow is stored
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ovf_pend_r <= 1'b0;
        end else if (sub_ovf && (counter_hold_request_r || ovf_pend_r)) begin
            ovf_pend_r <= 1'b1; // [RULE_05]
        end else if (!counter_hold_request_r || sec_wr) begin
            ovf_pend_r <= 1'b0; // [RULE_05] [RULE_06]
        end
    end

    // Calendar load decode
    always_comb begin
        ld.en = WR;
        ld.data = WDATA[6:0];
        case (ADDR)
            rtc_hold_pkg::ADDR_SEC: ld.field = rtc_hold_pkg::FLD_SEC;
            rtc_hold_pkg::ADDR_MIN: ld.field = rtc_hold_pkg::FLD_MIN;
            rtc_hold_pkg::ADDR_HOUR: ld.field = rtc_hold_pkg::FLD_HOUR;
            rtc_hold_pkg::ADDR_DAY: ld.field = rtc_hold_pkg::FLD_DAY;
            rtc_hold_pkg::ADDR_WEEK: ld.field = rtc_hold_pkg::FLD_WEEK;
            rtc_hold_pkg::ADDR_MONTH: ld.field = rtc_hold_pkg::FLD_MONTH;
            rtc_hold_pkg::ADDR_YEAR: ld.field = rtc_hold_pkg::FLD_YEAR;
            default: begin
                ld.en = 1'b0;
                ld.field = rtc_hold_pkg::FLD_SEC;
            end
        endcase
    end

    rtc_calendar u_calendar (
        .clk(CLK),
        .arst_n(ARST_N),
        .tick(cal_tick),
        .ld(ld),
        .q(cal_q)
    );

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = '0;
        case (ADDR)
            rtc_hold_pkg::ADDR_CTRL: begin
                rd_mux[rtc_hold_pkg::CTRL_RUN_BIT] = rtc_run_enable_r;
                rd_mux[rtc_hold_pkg::CTRL_HOLD_BIT] = counter_hold_request_r;
            end
            rtc_hold_pkg::ADDR_STAT: begin
                rd_mux[rtc_hold_pkg::STAT_HOLD_BIT] = HOLD_STATUS;
                rd_mux[rtc_hold_pkg::STAT_PEND_BIT] = ovf_pend_r;
            end
            rtc_hold_pkg::ADDR_SUB: rd_mux[rtc_hold_pkg::SUB_W-1:0] = sub_r;
            rtc_hold_pkg::ADDR_SEC: rd_mux[5:0] = cal_q.sec;
            rtc_hold_pkg::ADDR_MIN: rd_mux[5:0] = cal_q.min;
            rtc_hold_pkg::ADDR_HOUR: rd_mux[4:0] = cal_q.hour;
            rtc_hold_pkg::ADDR_DAY: rd_mux[4:0] = cal_q.day;
            rtc_hold_pkg::ADDR_WEEK: rd_mux[2:0] = cal_q.week;
            rtc_hold_pkg::ADDR_MONTH: rd_mux[3:0] = cal_q.month;
            rtc_hold_pkg::ADDR_YEAR: rd_mux[6:0] = cal_q.year;
            default: ;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= '0;
        end else begin
            RDATA <= RD ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    sequence late_hold_s;
        $rose(counter_hold_request_r) && slow_r;
    endsequence

    sequence late_hold_kept_s;
        late_hold_s ##1 counter_hold_request_r;
    endsequence

    freeze_hold_a: assert property ( // [RULE_01]
        $past(counter_hold_request_r) && !$past(ld.en) |-> cal_q == $past(cal_q))
        else $error("calendar moved during hold");
    count_run_a: assert property ( // [RULE_01]
        !counter_hold_request_r && sub_ovf && !ld.en |=> cal_q.sec != $past(cal_q.sec))
        else $error("calendar did not count outside hold");
    status_fast_a: assert property ( // [RULE_04]
        $rose(counter_hold_request_r) && !slow_r |=> HOLD_STATUS)
        else $error("hold status late");
    status_late_low_a: assert property ( // [RULE_07]
        late_hold_s |=> !HOLD_STATUS)
        else $error("late hold status rose too early");
    status_late_high_a: assert property ( // [RULE_08]
        late_hold_kept_s |=> HOLD_STATUS)
        else $error("late hold status not up after two cycles");
    status_drop_a: assert property ( // [RULE_09]
        !counter_hold_request_r |=> !HOLD_STATUS)
        else $error("hold status stayed after release");
    pend_keep_a: assert property ( // [RULE_05]
        $fell(counter_hold_request_r) && ovf_pend_r && !ld.en
        |=> cal_q.sec != $past(cal_q.sec))
        else $error("stored overflow not applied");
    pend_drop_a: assert property ( // [RULE_06]
        counter_hold_request_r && sec_wr && !sub_ovf |=> !ovf_pend_r)
        else $error("stored overflow kept after seconds write");
endmodule
`default_nettype wire

// ===== verification/rtc_counter_access_hold_bench.sv
// Self-checking bench for the calendar counter hold block
`timescale 1ns/1ps
`default_nettype none
module rtc_counter_access_hold_bench;
    logic CLK;
    logic ARST_N;
    logic [rtc_hold_pkg::ADDR_W-1:0] ADDR;
    logic [rtc_hold_pkg::DATA_W-1:0] WDATA;
    logic WR;
    logic RD;
    logic STANDBY_EXIT;
    logic [rtc_hold_pkg::DATA_W-1:0] RDATA;
    logic HOLD_STATUS;
    int n_errors = 0;
    int checks_done = 0;

    rtc_counter_access_hold uut (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .ADDR(ADDR),
        .WDATA(WDATA),
        .WR(WR),
        .RD(RD),
        .STANDBY_EXIT(STANDBY_EXIT),
        .RDATA(RDATA),
        .HOLD_STATUS(HOLD_STATUS)
    );

    // 40 MHz operating clock
    always #12.5 CLK = ~CLK;

    // Compare one value, report and count a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One-cycle write strobe; a gap cycle follows so strobes never double-assign
    task automatic wr(input logic [rtc_hold_pkg::ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [rtc_hold_pkg::ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask

    // Reset values, unmapped and read-only places
    task automatic reset_test;
        logic [rtc_hold_pkg::ADDR_W-1:0] a [7];
        logic [31:0] e [7];
        logic [31:0] v;
        a = '{rtc_hold_pkg::ADDR_CTRL, rtc_hold_pkg::ADDR_STAT, rtc_hold_pkg::ADDR_SEC,
              rtc_hold_pkg::ADDR_DAY, rtc_hold_pkg::ADDR_MONTH, rtc_hold_pkg::ADDR_YEAR, 8'h30};
        e = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
        check(32'(HOLD_STATUS), 32'h0);
        wr(rtc_hold_pkg::ADDR_STAT, 32'h3);
        wr(8'h30, 32'hFF);
        for (int i = 0; i < 7; i++) begin
            // Calendar places are only read under a hold
            if (i == 2) begin
                wr(rtc_hold_pkg::ADDR_CTRL, 32'h2);
            end
            rd(a[i], v);
            check(v, e[i]);
        end
        @(posedge CLK);
        #1 check(RDATA, 32'h0);
        wr(rtc_hold_pkg::ADDR_CTRL, 32'h0);
        $display("reset test done");
    endtask

    // Overflow during a hold is kept and applied at release
    task automatic overflow_test;
        logic [31:0] v;
        logic [31:0] w;
        int i;
        wr(rtc_hold_pkg::ADDR_CTRL, 32'h1);
        for (i = 0; i < 40000; i++) begin
            rd(rtc_hold_pkg::ADDR_SUB, v);
            if (v >= 32'h0000FFC0) break;
        end
        if (i == 40000) begin
            check(32'h0, 32'h1);
            stop_test();
        end
        // Hold taken well ahead of the wrap so the overflow lands inside it
        wr(rtc_hold_pkg::ADDR_CTRL, 32'h3);
        rd(rtc_hold_pkg::ADDR_SUB, v);
        rd(rtc_hold_pkg::ADDR_SUB, w);
        check(w - v, 32'h2);
        wr(rtc_hold_pkg::ADDR_MIN, 32'h2A);
        rd(rtc_hold_pkg::ADDR_MIN, v);
        check(v, 32'h2A);
        for (i = 0; i < 100; i++) begin
            rd(rtc_hold_pkg::ADDR_STAT, v);
            if (v[1] === 1'b1) break;
        end
        check(v, 32'h3);
        if (i == 100) begin
            stop_test();
        end
        rd(rtc_hold_pkg::ADDR_SEC, v);
        check(v, 32'h0);
        wr(rtc_hold_pkg::ADDR_CTRL, 32'h1);
        rd(rtc_hold_pkg::ADDR_STAT, v);
        check(v, 32'h0);
        // Seconds are only looked at under a fresh hold
        wr(rtc_hold_pkg::ADDR_CTRL, 32'h3);
        rd(rtc_hold_pkg::ADDR_SEC, v);
        check(v, 32'h1);
        wr(rtc_hold_pkg::ADDR_SEC, 32'h05);
        rd(rtc_hold_pkg::ADDR_STAT, v);
        check(v, 32'h1);
        rd(rtc_hold_pkg::ADDR_SEC, v);
        check(v, 32'h5);
        wr(rtc_hold_pkg::ADDR_CTRL, 32'h1);
        $display("overflow test done");
    endtask

    // Hold request with an optional run rise or standby exit in the same cycle or the cycle before it
    task automatic hold_seq(input logic sb, input int lead, input logic run_rise);
        int lat;
        lat = (sb || run_rise) ? 2 : 1;
        @(posedge CLK);
        if (lead == 1) begin
            WR <= run_rise;
            ADDR <= rtc_hold_pkg::ADDR_CTRL;
            WDATA <= 32'h1;
            STANDBY_EXIT <= sb;
            @(posedge CLK);
        end
        WR <= 1'b1;
        ADDR <= rtc_hold_pkg::ADDR_CTRL;
        WDATA <= 32'h3;
        STANDBY_EXIT <= sb && lead == 0;
        @(posedge CLK);
        WR <= 1'b0;
        STANDBY_EXIT <= 1'b0;
        for (int i = 0; i < lat; i++) begin
            #1 check(32'(HOLD_STATUS), 32'h0);
            @(posedge CLK);
        end
        #1 check(32'(HOLD_STATUS), 32'h1);
        wr(rtc_hold_pkg::ADDR_CTRL, 32'h1);
        #1 check(32'(HOLD_STATUS), 32'h1);
        @(posedge CLK);
        #1 check(32'(HOLD_STATUS), 32'h0);
    endtask

    // Plain, run-rise and standby-exit cases, event in same or previous cycle
    task automatic late_test;
        hold_seq(1'b0, 0, 1'b0);
        for (int lead = 0; lead < 2; lead++) begin
            wr(rtc_hold_pkg::ADDR_CTRL, 32'h0);
            hold_seq(1'b0, lead, 1'b1);
            hold_seq(1'b1, lead, 1'b0);
        end
        $display("late hold test done");
    endtask

    initial begin
        CLK = 1'b0;
        ARST_N = 1'b0;
        ADDR = '0;
        WDATA = '0;
        WR = 1'b0;
        RD = 1'b0;
        STANDBY_EXIT = 1'b0;
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        reset_test();
        overflow_test();
        late_test();
        stop_test();
    end
endmodule
`default_nettype wire
